// ===== sar_adc_cfg.svh
// Constants of the converter control block.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
`define RESULT_WIDTH 16
`define ABORT_PATTERN 16'hFF00
`define SIGN_BIT 15
`define CONV_TIME_NS 1160
`define CLK_PERIOD_NS 100
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define CONV_CNT_WIDTH 5
`define PINS_IDLE 6'h3C
`endif

// ===== sar_adc_pkg.sv
// Types of the converter control block.
package sar_adc_pkg;
    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_CONVERT = 3'b010,
        ST_NAP = 3'b011,
        ST_DOWN = 3'b100
    } phase_e;
    typedef struct packed {
        logic conversion_start_n;
        logic chip_select_n;
        logic frame_sync;
        logic serial_clock;
        logic power_down_pin;
        logic output_format_select;
    } pins_s;
endpackage

// ===== sync2.sv
// Two-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module sync2 import sar_adc_pkg::*; (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Pins.
    input wire pins_s async_i,
    output pins_s sync_o
);
    typedef struct packed {
        pins_s meta;
        pins_s sync;
    } state_s;
    state_s state_r;
    state_s state_nxt;
    always_comb begin
        state_nxt = state_r;
        state_nxt.meta = async_i;
        state_nxt.sync = state_r.meta;
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= '{meta: `PINS_IDLE, sync: `PINS_IDLE};
        end else begin
            state_r <= state_nxt;
        end
    end
    assign sync_o = state_r.sync;
endmodule // sync2

// ===== serial_out.sv
// Serial result shifter with frame control.
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module serial_out import sar_adc_pkg::*; (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Frame control.
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic shift_i,
    input wire logic [15:0] word_i,
    // Serial data pin.
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    input wire logic drive_i
);
    typedef struct packed {
        logic [15:0] shreg;
        logic oe;
    } state_s;
    state_s state_r;
    state_s state_nxt;
    always_comb begin
        state_nxt = state_r;
        state_nxt.oe = drive_i;
        if (clear_i) begin
            state_nxt.shreg = 16'h0000;
        end else if (load_i) begin
            state_nxt.shreg = word_i;
        end else if (shift_i) begin
            state_nxt.shreg = {state_r.shreg[14:0], 1'b0};
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign serial_data_out_o = state_r.shreg[`SIGN_BIT];
    assign serial_data_out_oe_o = state_r.oe;
endmodule // serial_out

// ===== sar_adc_ctrl.sv
// Conversion control and serial readout of a 16-bit converter.
//
// Functional notes
// - Busy high throughout conversion only.
// - Start acts only with chip select low.
// - Frame sync, serial clock need chip select.
// - Power-down resets and powers down.
// - Format pin picks binary or complement.
// - Later bits shift on serial clock rise.
// - Start fall in sampling begins conversion.
// - Start high, select low begins sampling.
// - Sampling condition at end: straight sampling.
// - No sampling command: enter wait.
// - Start low at end: enter nap.
// - Start fall during conversion aborts it.
// - After abort result reads FF00.
// - Readout independent of conversion control.
// - Read during conversion gives previous result.
// - Select fall shows top bit, frame-sync high.
// - Frame-sync rise, or busy fall with frame-sync high, reloads.
// - New frame start aborts current frame.
// - Complement is binary with top inverted.
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module sar_adc_ctrl import sar_adc_pkg::*; (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Control pins.
    input wire logic conversion_start_n_i,
    input wire logic chip_select_n_i,
    input wire logic frame_sync_i,
    input wire logic serial_clock_i,
    input wire logic power_down_pin_i,
    input wire logic output_format_select_i,
    // Converter core.
    input wire logic [15:0] sample_code_i,
    output logic sampling_o,
    output logic nap_o,
    output logic powered_down_o,
    // Status and data.
    output logic busy_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o
);
    typedef struct packed {
        phase_e phase;
        logic [`CONV_CNT_WIDTH-1:0] conv_cnt;
        logic qual_start_n;
        logic cs_n_d;
        logic fs_d;
        logic sclk_d;
        logic fell_seen;
        logic [15:0] result;
        logic busy;
    } state_s;
    localparam logic [`CONV_CNT_WIDTH-1:0] CONV_LAST =
        `CONV_CNT_WIDTH'(`CONV_CYCLES - 1);

    state_s state_r;
    state_s state_nxt;
    pins_s pins_raw;
    pins_s pins;
    logic load;
    logic shift;
    logic clear;
    logic drive;

    // Converts a straight binary code to the selected format.
    function automatic logic [15:0] format_code(input logic [15:0] code, input logic twos);
        format_code = twos ? {~code[`SIGN_BIT], code[14:0]} : code;
    endfunction

    assign pins_raw = '{conversion_start_n: conversion_start_n_i,
                        chip_select_n: chip_select_n_i,
                        frame_sync: frame_sync_i,
                        serial_clock: serial_clock_i,
                        power_down_pin: power_down_pin_i,
                        output_format_select: output_format_select_i};

    sync2 u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    logic q_fall;
    logic q_high;
    logic fs_q;
    logic sclk_q;
    logic cs_fall;
    logic fs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic busy_fall;

    always_comb begin
        state_nxt = state_r;
        q_fall = 1'b0;
        q_high = 1'b0;
        if (!pins.chip_select_n) begin
            state_nxt.qual_start_n = pins.conversion_start_n;
        end
        q_fall = state_r.qual_start_n && !state_nxt.qual_start_n;
        q_high = state_nxt.qual_start_n && !pins.chip_select_n;
        fs_q = pins.frame_sync && !pins.chip_select_n;
        sclk_q = pins.serial_clock && !pins.chip_select_n;
        state_nxt.cs_n_d = pins.chip_select_n;
        state_nxt.fs_d = fs_q;
        state_nxt.sclk_d = sclk_q;
        cs_fall = state_r.cs_n_d && !pins.chip_select_n;
        fs_rise = !state_r.fs_d && fs_q;
        sclk_rise = !state_r.sclk_d && sclk_q;
        sclk_fall = state_r.sclk_d && !sclk_q;
        busy_fall = 1'b0;
        case (state_r.phase)
            ST_WAIT, ST_NAP: begin
                if (q_high) begin
                    state_nxt.phase = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (q_fall) begin
                    state_nxt.phase = ST_CONVERT;
                    state_nxt.conv_cnt = '0;
                    state_nxt.busy = 1'b1;
                end
            end
            ST_CONVERT: begin
                if (q_fall) begin
                    state_nxt.phase = ST_WAIT;
                    state_nxt.busy = 1'b0;
                    busy_fall = 1'b1;
                    state_nxt.result = `ABORT_PATTERN;
                end else if (state_r.conv_cnt == CONV_LAST) begin
                    state_nxt.busy = 1'b0;
                    busy_fall = 1'b1;
                    state_nxt.result = sample_code_i;
                    if (q_high) begin
                        state_nxt.phase = ST_SAMPLE;
                    end else if (!state_nxt.qual_start_n) begin
                        state_nxt.phase = ST_NAP;
                    end else begin
                        state_nxt.phase = ST_WAIT;
                    end
                end else begin
                    state_nxt.conv_cnt = state_r.conv_cnt + `CONV_CNT_WIDTH'(1);
                end
            end
            ST_DOWN: begin
                if (!pins.power_down_pin) begin
                    state_nxt.phase = ST_WAIT;
                end
            end
            default: begin
                state_nxt.phase = ST_WAIT;
            end
        endcase
        load = cs_fall || fs_rise || (busy_fall && fs_q);
        if (load || pins.chip_select_n) begin
            state_nxt.fell_seen = 1'b0;
        end else if (sclk_fall) begin
            state_nxt.fell_seen = 1'b1;
        end
        shift = sclk_rise && state_r.fell_seen && !load;
        clear = pins.power_down_pin;
        if (pins.power_down_pin) begin
            state_nxt = '0;
            state_nxt.phase = ST_DOWN;
            state_nxt.qual_start_n = 1'b1;
            state_nxt.cs_n_d = 1'b1;
            load = 1'b0;
            shift = 1'b0;
        end
        drive = !pins.chip_select_n && !pins.power_down_pin;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= '{phase: ST_WAIT, conv_cnt: '0, qual_start_n: 1'b1, cs_n_d: 1'b1,
                         fs_d: 1'b0, sclk_d: 1'b0, fell_seen: 1'b0, result: 16'h0000,
                         busy: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    serial_out u_serial (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(clear),
        .load_i(load),
        .shift_i(shift),
        .word_i(format_code(state_nxt.result, pins.output_format_select)),
        .serial_data_out_o(serial_data_out_o),
        .serial_data_out_oe_o(serial_data_out_oe_o),
        .drive_i(drive)
    );

    assign busy_o = state_r.busy;
    assign sampling_o = (state_r.phase == ST_SAMPLE);
    assign nap_o = (state_r.phase == ST_NAP);
    assign powered_down_o = (state_r.phase == ST_DOWN);
endmodule // sar_adc_ctrl

// ===== sar_adc_ctrl_assertions.sv
// Assertion checker of the converter control block.
`timescale 1ns/1ps
module sar_adc_chk (
    // Clock, reset and pins.
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic chip_select_n_i,
    input wire logic power_down_pin_i,
    // Status and data.
    input wire logic sampling_o,
    input wire logic nap_o,
    input wire logic powered_down_o,
    input wire logic busy_o,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    busy_excl_a: assert property (busy_o |-> !sampling_o && !nap_o && !powered_down_o)
        else $error("busy beside another phase");
    busy_len_a: assert property ($rose(busy_o) |-> ##[1:12] !busy_o)
        else $error("busy too long");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(sampling_o))
        else $error("conversion not from sampling");
    start_qual_a: assert property (chip_select_n_i [*5] |-> !$rose(busy_o))
        else $error("start taken without select");
    sdo_idle_a: assert property ((chip_select_n_i && !power_down_pin_i) [*5]
        |-> $stable(serial_data_out_o))
        else $error("data moved without select");
    oe_off_a: assert property (chip_select_n_i [*5] |-> !serial_data_out_oe_o)
        else $error("data driven without select");
    oe_on_a: assert property ((!chip_select_n_i && !power_down_pin_i) [*5]
        |-> serial_data_out_oe_o)
        else $error("data not driven");
    pd_down_a: assert property (power_down_pin_i [*5]
        |-> powered_down_o && !busy_o && !serial_data_out_oe_o)
        else $error("power-down not taken");
    cover property ($fell(busy_o) ##1 sampling_o);
    cover property ($fell(busy_o) ##1 nap_o);
    cover property (powered_down_o);
endmodule // sar_adc_chk

bind sar_adc_ctrl sar_adc_chk chk_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .chip_select_n_i(chip_select_n_i), .power_down_pin_i(power_down_pin_i),
    .sampling_o(sampling_o), .nap_o(nap_o), .powered_down_o(powered_down_o),
    .busy_o(busy_o), .serial_data_out_o(serial_data_out_o),
    .serial_data_out_oe_o(serial_data_out_oe_o));

// ===== host_model.sv
// Host model driving start, select and serial clock.
`timescale 1ns/1ps
module host_model (
    // Clock and data.
    input wire logic clk_i,
    input wire logic sdo_i,
    // Pins.
    output logic start_n_o,
    output logic cs_n_o,
    output logic fs_o,
    output logic sclk_o
);
    initial begin
        start_n_o = 1'b1;
        cs_n_o = 1'b1;
        fs_o = 1'b1;
        sclk_o = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic conv();
        cs_n_o = 1'b0;
        start_n_o = 1'b1;
        step(6);
        start_n_o = 1'b0;
    endtask
    task automatic set_st(input logic v);
        start_n_o = v;
        step(1);
    endtask
    task automatic reframe();
        cs_n_o = 1'b1;
        step(1);
        cs_n_o = 1'b0;
        step(5);
    endtask
    task automatic set_cs(input logic v);
        cs_n_o = v;
        step(1);
    endtask
    task automatic fsframe();
        fs_o = 1'b0;
        step(4);
        fs_o = 1'b1;
        step(5);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            sclk_o = 1'b0;
            step(4);
            sclk_o = 1'b1;
            step(4);
        end
    endtask
    task automatic shift_in(output logic [15:0] w);
        w[15] = sdo_i;
        for (int i = 14; i >= 0; i--) begin
            pulse(1);
            w[i] = sdo_i;
        end
    endtask
    task automatic rd(output logic [15:0] w);
        reframe();
        shift_in(w);
    endtask
endmodule // host_model

// ===== tb_top.sv
// Testbench of the converter control block.
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module tb_top;
    logic clk, rst_n, st_n, cs_n, fs, sclk, pd, fmt, samp, nap, pdn, busy, serial_data_out, oe;
    logic [15:0] code, w;
    logic sdo_pin;
    int fail_count, checks_done;
    sar_adc_ctrl dut_u (.core_clk_i(clk), .reset_n_i(rst_n), .conversion_start_n_i(st_n),
        .chip_select_n_i(cs_n), .frame_sync_i(fs), .serial_clock_i(sclk),
        .power_down_pin_i(pd), .output_format_select_i(fmt), .sample_code_i(code),
        .sampling_o(samp), .nap_o(nap), .powered_down_o(pdn), .busy_o(busy),
        .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe));
    // The host sees the inverse of the data pin while it is not driven.
    assign sdo_pin = oe ? serial_data_out : ~serial_data_out;
    host_model host_u (.clk_i(clk), .sdo_i(sdo_pin), .start_n_o(st_n), .cs_n_o(cs_n),
        .fs_o(fs), .sclk_o(sclk));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic v);
        for (int n = 0; busy !== v; n++) begin
            if (n > 200) begin
                fail_count++;
                end_sim();
            end
            @(negedge clk);
        end
    endtask
    task automatic t_cs();
        host_u.set_st(1'b1);
        host_u.set_st(1'b0);
        host_u.step(4);
        chk(busy, 1'b0);
        chk(oe, 1'b0);
    endtask
    task automatic t_conv(input logic [15:0] c, input logic f, input logic [15:0] e);
        int n;
        code = c;
        fmt = f;
        host_u.conv();
        wb(1'b1);
        for (n = 0; busy === 1'b1 && n < 50; n++) @(negedge clk);
        chk(16'(n), 16'(`CONV_CYCLES));
        @(negedge clk);
        chk(nap, 1'b1);
        host_u.rd(w);
        chk(w, e);
    endtask
    task automatic t_b2b();
        fmt = 1'b0;
        host_u.conv();
        wb(1'b1);
        host_u.set_st(1'b1);
        wb(1'b0);
        @(negedge clk);
        chk(samp, 1'b1);
        host_u.set_st(1'b0);
        wb(1'b1);
        wb(1'b0);
    endtask
    task automatic t_abort();
        host_u.conv();
        wb(1'b1);
        host_u.step(2);
        host_u.set_st(1'b1);
        host_u.set_st(1'b0);
        host_u.step(5);
        chk(busy, 1'b0);
        chk({samp, nap}, 2'b00);
        host_u.rd(w);
        chk(w, 16'hFF00);
    endtask
    task automatic t_lat();
        code = 16'h1234;
        host_u.conv();
        wb(1'b1);
        host_u.reframe();
        chk(serial_data_out, 1'b1);
        wb(1'b0);
        host_u.step(4);
        chk(serial_data_out, 1'b0);
    endtask
    task automatic t_fs();
        host_u.reframe();
        host_u.pulse(5);
        host_u.fsframe();
        host_u.shift_in(w);
        chk(w, 16'h1234);
    endtask
    task automatic t_wait();
        host_u.conv();
        wb(1'b1);
        host_u.set_st(1'b1);
        host_u.step(3);
        host_u.set_cs(1'b1);
        wb(1'b0);
        @(negedge clk);
        chk({samp, nap}, 2'b00);
        host_u.set_cs(1'b0);
        host_u.step(3);
        chk(samp, 1'b1);
    endtask
    task automatic t_pd();
        pd = 1'b1;
        host_u.set_st(1'b1);
        host_u.set_st(1'b0);
        host_u.step(5);
        chk({pdn, busy, oe}, 3'b100);
        pd = 1'b0;
        host_u.step(6);
        host_u.rd(w);
        chk(w, 16'h0000);
    endtask
    initial begin
        rst_n = 1'b0;
        pd = 1'b0;
        fmt = 1'b0;
        code = 16'h0000;
        fail_count = 0;
        checks_done = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        host_u.step(2);
        t_cs();
        t_conv(16'h1234, 1'b0, 16'h1234);
        t_conv(16'h0000, 1'b1, 16'h8000);
        t_conv(16'hFFFF, 1'b1, 16'h7FFF);
        t_b2b();
        t_abort();
        t_lat();
        t_fs();
        t_wait();
        t_pd();
        end_sim();
    end
endmodule // tb_top
